// ===== logic/sis_init_seq.sv
// SDRAM power-up initialization sequencer with DFI handover and done flag
// What this block does
// - Hold DFI memory reset low for reset-hold count times 1024 clocks.
// - Then NOP/deselect, clock enable low, for pre-enable count times 1024.
// - Raise clock enable, NOP/deselect for post-enable count times 1024.
// - DDR4 loads MR3, MR6, MR5, MR4, MR2, MR1, each then waits tMRD.
// - DDR4 finishes with MR0 main value, then waits the longer tMOD.
// - DDR3 loads MR2, MR3, MR1, MR0, each then waits tMRD.
// - Issue ZQ calibration long, wait ZQ init count times 32 clocks.
// - Initialization completes only after the ZQ wait has expired.
// - Writing 0x00040001 to PHY init trigger hands DFI control to PHY.
// - An init-done flag tells software the sequence has finished.
`timescale 1ns/1ps
module sis_init_seq
   import sis_pkg::*;
(
   input  wire logic                  CLK_I,
   input  wire logic                  RST_N_I,
   input  wire logic                  START_I,
   input  wire logic                  DDR4_SEL_I,
   input  wire sis_pkg::sis_cfg_t     CFG_I,
   input  wire logic                  PHY_INIT_WR_I,
   input  wire logic [31:0]           PHY_INIT_DATA_I,
   input  wire logic                  HOST_REQ_I,
   output logic                       DFI_RESET_N_O,
   output logic                       DFI_CKE_O,
   output sis_pkg::sis_dfi_cmd_t      DFI_CMD_O,
   output logic                       DFI_OWNER_PHY_O,
   output logic                       INIT_BUSY_O,
   output logic                       INIT_DONE_O,
   output logic                       HOST_READY_O,
   output logic                       HOST_ACCEPT_O
);
   import sis_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RST_HOLD,
      ST_PRE_CKE,
      ST_POST_CKE,
      ST_MRS,
      ST_MRS_WAIT,
      ST_ZQ,
      ST_ZQ_WAIT,
      ST_DONE
   } sis_state_t;

   sis_state_t       state_r;
   sis_state_t       state_nxt;
   sis_cfg_t         cfg_r;
   sis_cfg_t         cfg_nxt;
   logic             ddr4_r;
   logic             ddr4_nxt;
   logic [2:0]       step_r;
   logic [2:0]       step_nxt;
   logic             reset_n_r;
   logic             reset_n_nxt;
   logic             cke_r;
   logic             cke_nxt;
   logic             done_r;
   logic             done_nxt;
   logic             owner_r;
   logic             owner_nxt;
   sis_dfi_cmd_t     cmd_r;
   sis_dfi_cmd_t     cmd_nxt;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_cycles;
   logic             tmr_expired;
   logic             start_ok;
   logic [CNT_W-1:0] cyc_r;
   logic [CNT_W-1:0] cyc_nxt;

   // Interval in clocks; zero programmed still waits one clock
   function automatic logic [CNT_W-1:0] cycles_of(input logic [15:0] v,
                                                  input int sh);
      logic [CNT_W-1:0] c;
      c = {16'h0000, v} << sh;
      return (c == CNT_ZERO) ? CNT_ONE : c;
   endfunction : cycles_of

   function automatic logic [2:0] mr_of(input logic d4,
                                        input logic [2:0] st);
      return d4 ? DDR4_MR_ORDER[st] : DDR3_MR_ORDER[st[1:0]];
   endfunction : mr_of

   function automatic logic is_last(input logic d4, input logic [2:0] st);
      return d4 ? (st == DDR4_LAST) : (st == DDR3_LAST);
   endfunction : is_last

   function automatic logic [15:0] mr_val(input sis_cfg_t c,
                                          input logic [2:0] a);
      logic [15:0] v;
      v = c.main_mode_value;
      unique case (a)
         3'h0: v = c.main_mode_value;
         3'h1: v = c.mode1_value;
         3'h2: v = c.mode2_value;
         3'h3: v = c.mode3_value;
         3'h4: v = c.mode4_value;
         3'h5: v = c.mode5_value;
         3'h6: v = c.mode6_value;
         default: v = c.main_mode_value;
      endcase
      return v;
   endfunction : mr_val

   function automatic sis_dfi_cmd_t mrs_cmd(input sis_cfg_t c,
                                            input logic d4,
                                            input logic [2:0] st);
      sis_dfi_cmd_t k;
      k.cmd     = SIS_CMD_MRS;
      k.mr_addr = mr_of(d4, st);
      k.mr_data = mr_val(c, k.mr_addr);
      return k;
   endfunction : mrs_cmd

   sis_wait_timer u_timer (
      .clk_i     (CLK_I),
      .rst_n_i   (RST_N_I),
      .load_i    (tmr_load),
      .cycles_i  (tmr_cycles),
      .expired_o (tmr_expired)
   );

   // Handover is sticky until reset, so re-inits need no new write
   always_comb begin
      owner_nxt = owner_r;
      if (PHY_INIT_WR_I && (PHY_INIT_DATA_I == PHY_HANDOVER)) begin
         owner_nxt = 1'b1;
      end
   end

   // Start is honoured only from rest and only once the PHY owns DFI
   assign start_ok = START_I && owner_r &&
                     ((state_r == ST_IDLE) || (state_r == ST_DONE));

   always_comb begin
      state_nxt   = state_r;
      cfg_nxt     = cfg_r;
      ddr4_nxt    = ddr4_r;
      step_nxt    = step_r;
      reset_n_nxt = reset_n_r;
      cke_nxt     = cke_r;
      done_nxt    = done_r;
      cmd_nxt     = cmd_r;
      tmr_load    = 1'b0;
      tmr_cycles  = CNT_ONE;
      unique case (state_r)
         ST_IDLE, ST_DONE: begin
            if (start_ok) begin
               // Config is frozen for the whole run
               cfg_nxt     = CFG_I;
               ddr4_nxt    = DDR4_SEL_I;
               reset_n_nxt = 1'b0;
               cke_nxt     = 1'b0;
               done_nxt    = 1'b0;
               cmd_nxt     = DFI_CMD_IDLE;
               tmr_load    = 1'b1;
               tmr_cycles  = cycles_of(CFG_I.reset_hold_count,
                                       X1024_SHIFT);
               state_nxt   = ST_RST_HOLD;
            end
         end
         ST_RST_HOLD: begin
            if (tmr_expired) begin
               reset_n_nxt = 1'b1;
               tmr_load    = 1'b1;
               tmr_cycles  = cycles_of(cfg_r.pre_clock_enable_count,
                                       X1024_SHIFT);
               state_nxt   = ST_PRE_CKE;
            end
         end
         ST_PRE_CKE: begin
            if (tmr_expired) begin
               cke_nxt    = 1'b1;
               tmr_load   = 1'b1;
               tmr_cycles = cycles_of(cfg_r.post_clock_enable_count,
                                      X1024_SHIFT);
               state_nxt  = ST_POST_CKE;
            end
         end
         ST_POST_CKE: begin
            if (tmr_expired) begin
               step_nxt  = STEP_FIRST;
               cmd_nxt   = mrs_cmd(cfg_r, ddr4_r, STEP_FIRST);
               state_nxt = ST_MRS;
            end
         end
         ST_MRS: begin
            cmd_nxt  = DFI_CMD_IDLE;
            tmr_load = 1'b1;
            if (ddr4_r && is_last(ddr4_r, step_r)) begin
               tmr_cycles = cycles_of({8'h00, cfg_r.mode_reg_update_delay},
                                      NO_SHIFT);
            end else begin
               tmr_cycles = cycles_of({8'h00, cfg_r.mode_reg_delay},
                                      NO_SHIFT);
            end
            state_nxt = ST_MRS_WAIT;
         end
         ST_MRS_WAIT: begin
            if (tmr_expired) begin
               if (is_last(ddr4_r, step_r)) begin
                  cmd_nxt       = DFI_CMD_IDLE;
                  cmd_nxt.cmd   = SIS_CMD_ZQCL;
                  state_nxt     = ST_ZQ;
               end else begin
                  step_nxt  = step_r + 3'h1;
                  cmd_nxt   = mrs_cmd(cfg_r, ddr4_r, step_r + 3'h1);
                  state_nxt = ST_MRS;
               end
            end
         end
         ST_ZQ: begin
            cmd_nxt    = DFI_CMD_IDLE;
            tmr_load   = 1'b1;
            tmr_cycles = cycles_of(cfg_r.zq_init_count, X32_SHIFT);
            state_nxt  = ST_ZQ_WAIT;
         end
         ST_ZQ_WAIT: begin
            if (tmr_expired) begin
               done_nxt  = 1'b1;
               state_nxt = ST_DONE;
            end
         end
      endcase
   end

   // Helper count of cycles spent in the current state
   always_comb begin
      cyc_nxt = (state_nxt != state_r) ? CNT_ZERO : cyc_r + CNT_ONE;
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_r   <= ST_IDLE;
         cfg_r     <= '0;
         ddr4_r    <= 1'b0;
         step_r    <= STEP_FIRST;
         reset_n_r <= 1'b0;
         cke_r     <= 1'b0;
         done_r    <= 1'b0;
         owner_r   <= 1'b0;
         cmd_r     <= DFI_CMD_IDLE;
         cyc_r     <= CNT_ZERO;
      end else begin
         state_r   <= state_nxt;
         cfg_r     <= cfg_nxt;
         ddr4_r    <= ddr4_nxt;
         step_r    <= step_nxt;
         reset_n_r <= reset_n_nxt;
         cke_r     <= cke_nxt;
         done_r    <= done_nxt;
         owner_r   <= owner_nxt;
         cmd_r     <= cmd_nxt;
         cyc_r     <= cyc_nxt;
      end
   end

   assign DFI_RESET_N_O   = reset_n_r;
   assign DFI_CKE_O       = cke_r;
   assign DFI_CMD_O       = cmd_r;
   assign DFI_OWNER_PHY_O = owner_r;
   assign INIT_DONE_O     = done_r;
   assign INIT_BUSY_O     = (state_r != ST_IDLE) && (state_r != ST_DONE);
   // Host side is shut out until the last wait ends
   assign HOST_READY_O    = done_r;
   assign HOST_ACCEPT_O   = HOST_REQ_I && done_r;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_rst_hold_len;
      (state_r == ST_RST_HOLD && state_nxt != ST_RST_HOLD) |->
         (cyc_r == cycles_of(cfg_r.reset_hold_count, X1024_SHIFT) - CNT_ONE)
         && !DFI_RESET_N_O && !DFI_CKE_O;
   endproperty
   a_rst_hold_len: assert property (p_rst_hold_len)
      else $error("reset hold length wrong");

   property p_pre_cke;
      (state_r == ST_PRE_CKE) |->
         DFI_RESET_N_O && !DFI_CKE_O && DFI_CMD_O.cmd == SIS_CMD_NOP;
   endproperty
   a_pre_cke: assert property (p_pre_cke)
      else $error("pre clock enable phase not quiet");

   property p_cke_rise;
      $rose(DFI_CKE_O) |-> $past(state_r) == ST_PRE_CKE &&
         $past(cyc_r) == cycles_of(cfg_r.pre_clock_enable_count,
                                   X1024_SHIFT) - CNT_ONE;
   endproperty
   a_cke_rise: assert property (p_cke_rise)
      else $error("clock enable rose at wrong time");

   property p_mrs_gap;
      (DFI_CMD_O.cmd == SIS_CMD_MRS) |=>
         DFI_CMD_O.cmd == SIS_CMD_NOP && DFI_CKE_O;
   endproperty
   a_mrs_gap: assert property (p_mrs_gap)
      else $error("mode set not followed by deselect");

   property p_mrd_len;
      (state_r == ST_MRS_WAIT && state_nxt != ST_MRS_WAIT &&
       !(ddr4_r && is_last(ddr4_r, step_r))) |->
         cyc_r == cycles_of({8'h00, cfg_r.mode_reg_delay}, NO_SHIFT) - CNT_ONE;
   endproperty
   a_mrd_len: assert property (p_mrd_len)
      else $error("mode register delay length wrong");

   property p_mod_len;
      (state_r == ST_MRS_WAIT && state_nxt == ST_ZQ && ddr4_r) |->
         DFI_CMD_O.cmd == SIS_CMD_NOP && step_r == DDR4_LAST &&
         cyc_r == cycles_of({8'h00, cfg_r.mode_reg_update_delay},
                            NO_SHIFT) - CNT_ONE;
   endproperty
   a_mod_len: assert property (p_mod_len)
      else $error("final mode update delay wrong");

   property p_mrs_data;
      (DFI_CMD_O.cmd == SIS_CMD_MRS) |->
         DFI_CMD_O.mr_data == mr_val(cfg_r, DFI_CMD_O.mr_addr) &&
         (ddr4_r || DFI_CMD_O.mr_addr <= 3'h3);
   endproperty
   a_mrs_data: assert property (p_mrs_data)
      else $error("mode set carries wrong value");

   property p_zq_len;
      $rose(INIT_DONE_O) |-> $past(state_r) == ST_ZQ_WAIT &&
         $past(cyc_r) == cycles_of(cfg_r.zq_init_count, X32_SHIFT)
         - CNT_ONE;
   endproperty
   a_zq_len: assert property (p_zq_len)
      else $error("done before calibration wait ended");

   property p_host_shut;
      INIT_BUSY_O |-> !HOST_READY_O && !HOST_ACCEPT_O && !INIT_DONE_O;
   endproperty
   a_host_shut: assert property (p_host_shut)
      else $error("host traffic during init");

   property p_owner_first;
      !DFI_OWNER_PHY_O |-> state_r == ST_IDLE && !DFI_RESET_N_O;
   endproperty
   a_owner_first: assert property (p_owner_first)
      else $error("sequence ran before handover");
endmodule : sis_init_seq

// ===== logic/sis_pkg.sv
// Constants, types and orderings shared by the init sequencer files
package sis_pkg;
   localparam int          CNT_W         = 32;
   localparam int          X1024_SHIFT   = 10;
   localparam int          X32_SHIFT     = 5;
   localparam int          NO_SHIFT      = 0;
   localparam logic [31:0] PHY_HANDOVER  = 32'h00040001;
   localparam logic [2:0]  DDR4_LAST     = 3'h6;
   localparam logic [2:0]  DDR3_LAST     = 3'h3;
   localparam logic [2:0]  STEP_FIRST    = 3'h0;
   localparam logic [15:0] MR_DATA_RST   = 16'h0000;
   localparam logic [2:0]  MR_ADDR_RST   = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 32'h1;
   // Index 0 is the first load of the sequence
   localparam logic [6:0][2:0] DDR4_MR_ORDER =
      {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
   localparam logic [3:0][2:0] DDR3_MR_ORDER =
      {3'h0, 3'h1, 3'h3, 3'h2};

   typedef enum logic [1:0] {
      SIS_CMD_NOP,
      SIS_CMD_MRS,
      SIS_CMD_ZQCL
   } sis_cmd_t;

   typedef struct packed {
      logic [15:0] reset_hold_count;
      logic [15:0] pre_clock_enable_count;
      logic [15:0] post_clock_enable_count;
      logic [7:0]  mode_reg_delay;
      logic [7:0]  mode_reg_update_delay;
      logic [15:0] zq_init_count;
      logic [15:0] main_mode_value;
      logic [15:0] mode1_value;
      logic [15:0] mode2_value;
      logic [15:0] mode3_value;
      logic [15:0] mode4_value;
      logic [15:0] mode5_value;
      logic [15:0] mode6_value;
   } sis_cfg_t;

   typedef struct packed {
      sis_cmd_t    cmd;
      logic [2:0]  mr_addr;
      logic [15:0] mr_data;
   } sis_dfi_cmd_t;

   localparam sis_dfi_cmd_t DFI_CMD_IDLE =
      '{cmd: SIS_CMD_NOP, mr_addr: MR_ADDR_RST, mr_data: MR_DATA_RST};
endpackage : sis_pkg

// ===== logic/sis_wait_timer.sv
// Down-counting wait timer used for every interval of the sequence
`timescale 1ns/1ps
module sis_wait_timer
   import sis_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] cycles_i,
   output logic                  expired_o
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load_i) begin
         // Zero load would underflow; caller clamps, guard anyway
         cnt_nxt = (cycles_i == CNT_ZERO) ? CNT_ZERO : cycles_i - CNT_ONE;
      end else if (cnt_r != CNT_ZERO) begin
         cnt_nxt = cnt_r - CNT_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_r <= CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign expired_o = (cnt_r == CNT_ZERO);
endmodule : sis_wait_timer

// ===== verif/sis_sdram_model.sv
// Passive memory-side model that reports reset release, clock-enable rise, each command and done rise
`timescale 1ns/1ps
module sis_sdram_model
   import sis_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         reset_n_i,
   input  wire logic         cke_i,
   input  wire sis_dfi_cmd_t cmd_i,
   input  wire logic         busy_i,
   input  wire logic         done_i,
   output logic              ev_o,
   output logic [1:0]        kind_o,
   output sis_dfi_cmd_t      ev_cmd_o,
   output logic [31:0]       gap_o
);
   logic [3:0]  prev_r;
   logic [3:0]  prev_nxt;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        start_seen;

   // Gap counts cycles since the previous marker, marker cycle included
   always_comb begin
      prev_nxt   = {reset_n_i, cke_i, busy_i, done_i};
      start_seen = busy_i && !prev_r[1];
      ev_o       = 1'b0;
      kind_o     = 2'h0;
      ev_cmd_o   = DFI_CMD_IDLE;
      if (reset_n_i && !prev_r[3]) begin
         ev_o = 1'b1;
      end else if (cke_i && !prev_r[2]) begin
         ev_o   = 1'b1;
         kind_o = 2'h1;
      end else if (cmd_i.cmd != SIS_CMD_NOP) begin
         ev_o         = 1'b1;
         kind_o       = 2'h2;
         ev_cmd_o.cmd = cmd_i.cmd;
         // Address and data only mean something on a mode load
         if (cmd_i.cmd == SIS_CMD_MRS) begin
            ev_cmd_o.mr_addr = cmd_i.mr_addr;
            ev_cmd_o.mr_data = cmd_i.mr_data;
         end
      end else if (done_i && !prev_r[0]) begin
         ev_o   = 1'b1;
         kind_o = 2'h3;
      end
      ev_o    = ev_o && rst_n_i;
      cnt_nxt = (ev_o || start_seen) ? 32'h1 : cnt_r + 32'h1;
      gap_o   = cnt_r;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prev_r <= 4'h0;
         cnt_r  <= 32'h0;
      end else begin
         prev_r <= prev_nxt;
         cnt_r  <= cnt_nxt;
      end
   end
endmodule : sis_sdram_model

// ===== verif/test_sis_init_seq.sv
// Self-checking bench for the SDRAM init sequencer
`timescale 1ns/1ps
module test_sis_init_seq;
   import sis_pkg::*;
   typedef struct packed {
      logic [1:0]   kind;
      sis_dfi_cmd_t cmd;
      logic [31:0]  gap;
   } sis_note_t;
   localparam int LIMIT = 40000;
   logic         clk;
   logic         rst_n;
   logic         start;
   logic         ddr4_sel;
   sis_cfg_t     cfg;
   logic         wr;
   logic [31:0]  wdata;
   logic         host_req;
   logic         reset_n;
   logic         cke;
   sis_dfi_cmd_t cmd;
   logic         owner;
   logic         busy;
   logic         done;
   logic         ready;
   logic         accept;
   logic         ev;
   logic [1:0]   kind;
   sis_dfi_cmd_t ev_cmd;
   logic [31:0]  gap;
   logic         seq_done;
   sis_note_t    exp_q[$];
   sis_note_t    got;
   int           num_errors;
   int           cmp_count;
   int           cycles;
   integer       seed;

   sis_init_seq sis_init_seq_i (.CLK_I(clk), .RST_N_I(rst_n),
      .START_I(start), .DDR4_SEL_I(ddr4_sel), .CFG_I(cfg),
      .PHY_INIT_WR_I(wr), .PHY_INIT_DATA_I(wdata), .HOST_REQ_I(host_req),
      .DFI_RESET_N_O(reset_n), .DFI_CKE_O(cke), .DFI_CMD_O(cmd),
      .DFI_OWNER_PHY_O(owner), .INIT_BUSY_O(busy), .INIT_DONE_O(done),
      .HOST_READY_O(ready), .HOST_ACCEPT_O(accept));

   sis_sdram_model sis_sdram_model_i (.clk_i(clk), .rst_n_i(rst_n),
      .reset_n_i(reset_n), .cke_i(cke), .cmd_i(cmd), .busy_i(busy),
      .done_i(done), .ev_o(ev), .kind_o(kind), .ev_cmd_o(ev_cmd),
      .gap_o(gap));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // A zero interval still costs one cycle
   function automatic logic [31:0] eff(input logic [31:0] n);
      return (n == 32'h0) ? 32'h1 : n;
   endfunction : eff

   task automatic note(input logic [1:0] k, input sis_dfi_cmd_t c,
                       input logic [31:0] g);
      exp_q.push_back('{kind: k, cmd: c, gap: g});
   endtask : note

   task automatic launch(input logic d4, input logic zero);
      logic [191:0] rnd;
      sis_cfg_t    c;
      logic [2:0]  ord[$];
      logic [15:0] mv[0:7];
      logic [31:0] dly;
      rnd = {$random(seed), $random(seed), $random(seed),
             $random(seed), $random(seed), $random(seed)};
      c = rnd[175:0];
      c.reset_hold_count        = zero ? 16'h0 : 16'h1;
      c.pre_clock_enable_count  = zero ? 16'h0 : 16'h1;
      c.post_clock_enable_count = zero ? 16'h0 : 16'h1;
      c.mode_reg_delay          = {5'h0, c.mode_reg_delay[2:0]};
      c.mode_reg_update_delay   = {4'h0, c.mode_reg_update_delay[3:0]};
      c.zq_init_count           = zero ? 16'h0 : {14'h0, 2'h3};
      mv = '{c.main_mode_value, c.mode1_value, c.mode2_value, c.mode3_value,
             c.mode4_value, c.mode5_value, c.mode6_value, 16'h0};
      if (d4) begin
         ord = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
      end else begin
         ord = '{3'h2, 3'h3, 3'h1, 3'h0};
      end
      note(2'h0, DFI_CMD_IDLE, eff({6'h0, c.reset_hold_count, 10'h0}));
      note(2'h1, DFI_CMD_IDLE, eff({6'h0, c.pre_clock_enable_count, 10'h0}));
      dly = eff({6'h0, c.post_clock_enable_count, 10'h0});
      foreach (ord[i]) begin
         note(2'h2, '{SIS_CMD_MRS, ord[i], mv[ord[i]]}, dly);
         dly = 32'h1 + eff((d4 && ord[i] == 3'h0) ?
               {24'h0, c.mode_reg_update_delay} : {24'h0, c.mode_reg_delay});
      end
      note(2'h2, '{SIS_CMD_ZQCL, 3'h0, 16'h0}, dly);
      note(2'h3, DFI_CMD_IDLE, 32'h1 + eff({11'h0, c.zq_init_count, 5'h0}));
      @(posedge clk);
      cfg      <= c;
      ddr4_sel <= d4;
      start    <= 1'b1;
      @(posedge clk);
      // Config and mode select must have been captured at the start
      start    <= 1'b0;
      cfg      <= ~c;
      ddr4_sel <= !d4;
      repeat (4) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : launch

   task automatic run(input logic d4, input logic zero);
      launch(d4, zero);
      while (exp_q.size() != 0) @(posedge clk);
   endtask : run

   task automatic handover(input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      wdata <= d;
      // Start alongside the write must be refused
      start <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      start <= 1'b0;
      #1;
   endtask : handover

   always @(posedge clk) begin
      host_req <= 1'($random(seed));
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         seq_done = 1'b0;
      end else begin
         if (busy === 1'b1) seq_done = 1'b0;
         if (ev === 1'b1) begin
            if (exp_q.size() == 0) begin
               check(64'h1, 64'h0);
            end else begin
               got = exp_q.pop_front();
               check(64'({kind, ev_cmd, gap}),
                     64'(got));
               if (kind === 2'h3) seq_done = 1'b1;
            end
         end
         check(64'({done, ready, accept}),
               64'({seq_done, seq_done, seq_done & host_req}));
      end
   end

   initial begin
      seed = 9;
      {rst_n, start, ddr4_sel, wr} = 4'h0;
      cfg   = '0;
      wdata = 32'h0;
      num_errors = 0;
      cmp_count  = 0;
      cycles     = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      handover(32'h00040000);
      check(64'({owner, busy}), 64'h0);
      handover(PHY_HANDOVER);
      check(64'({owner, busy}), 64'h2);
      // Rank, gate and lane set-up stay with software, none driven here
      run(1'b1, 1'b0);
      run(1'b0, 1'b0);
      run(1'b1, 1'b1);
      run(1'b0, 1'b1);
      launch(1'b1, 1'b0);
      repeat (100) @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      exp_q.delete();
      @(posedge clk);
      #1;
      check(64'({reset_n, cke, cmd, owner, busy, done}),
            64'({2'h0, DFI_CMD_IDLE, 3'h0}));
      @(posedge clk);
      rst_n <= 1'b1;
      handover(PHY_HANDOVER);
      run(1'b1, 1'b0);
      end_of_test();
   end
endmodule : test_sis_init_seq
